// ==== ocf_defines.svh ====
// constants of the operations channel framer: octet codes, lengths, addresses, check sequence
// assumes inclusion by the framer file only
`ifndef OCF_DEFINES_SVH
`define OCF_DEFINES_SVH

// --------------------------------------------------------------------------
// octet codes
// --------------------------------------------------------------------------
`define OCF_FLAG 8'h7e
`define OCF_ESC 8'h7d
`define OCF_ESC_XOR 8'h20
`define OCF_ESC_FLAG 8'h5e
`define OCF_ESC_ESC 8'h5d
`define OCF_ID_PROBE 8'h01
`define OCF_ID_DRSP 8'h81

// --------------------------------------------------------------------------
// frame lengths and flag run
// --------------------------------------------------------------------------
`define OCF_MAX_LEN 7'h4b
`define OCF_MIN_LEN 7'h04
`define OCF_MAX_BODY 7'h49
`define OCF_PRE_FLAGS 3'h5
`define OCF_FIFO_DEPTH 8

// --------------------------------------------------------------------------
// unit addresses
// --------------------------------------------------------------------------
`define OCF_ADDR_ADJ 4'h0
`define OCF_ADDR_LTU 4'h1
`define OCF_ADDR_OFS 4'h2
`define OCF_ADDR_BCAST 4'hf

// --------------------------------------------------------------------------
// 16-bit check sequence, reflected form
// --------------------------------------------------------------------------
`define OCF_CRC_INIT 16'hffff
`define OCF_CRC_POLY 16'h8408
`define OCF_CRC_GOOD 16'hf0b8

`endif

// ==== ocf_pkg.sv ====
// types of the operations channel framer
// assumes the defines header is on the include path
package ocf_pkg;
  // addressing state of one side of the repeater
  typedef enum logic [1:0] {OCF_OFFLINE, OCF_DISC_READY, OCF_ONLINE} ocf_sm_e;
  // transmit octet scheduler
  typedef enum logic [1:0] {OCF_TX_FLAG, OCF_TX_DATA, OCF_TX_FCS1, OCF_TX_FCS2} ocf_tx_e;
endpackage

// ==== ocf_framer.sv ====
// operations channel octet framer, deframer and repeater addressing logic
// assumes bit strobes, sync loss levels and the forward stream come from logic on clk

`include "ocf_defines.svh"

// --------------------------------------------------------------------------
// word fifo
// --------------------------------------------------------------------------
module ocf_fifo #(
  parameter int W = 9,
  parameter int D = `OCF_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW-1:0] wr_next = (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
  wire [AW-1:0] rd_next = (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;

  // honest flags from the occupancy count
  assign in_ready = (cnt_reg != (AW + 1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];

  // storage
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push) wr_reg <= wr_next;
      if (pop) rd_reg <= rd_next;
      cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// Functional notes
// - offline side goes discovery-ready once its sync word loss clears
// - sync word loss in ready or online clears address and returns offline
// - probe in ready: hop plus one, address hop plus three, notify, respond, online
// - probe while online repeats hop, address, notify and response, staying online
// - online broadcast frames are processed and also handed on for forwarding
// - online frames to own address or zero are processed, not forwarded
// - frames for other units are handed to customer side for forwarding
// - forwarded frames go out when idle in ready, when available online
// - channel uses twenty bits per line frame, five octets per frame pair
// - octets start at bit one of first pair frame, sent lsb first
// - receive octet alignment found by hunting the flag octet in the bits
// - numeric fields go most significant octet first, lsb first per octet
// - text fields fixed length, first character first, ignored after null
// - channel is an octet stream and messages are whole octets
// - first octet: destination in low nibble, source in high nibble
// - address, message id, one message, then two check octets
// - at least one flag between frames, idle filled with flags
// - at least five flags precede each probe frame
// - frame at most 75 octets without flags or stuffing
// - transmit replaces flag and escape payload octets by escape pairs
// - receive restores escape pairs to flag and escape octets
// - escape followed by any other octet aborts the received frame
// - standard 16-bit check over unstuffed content, sent reversed bit order
// - frames failing the check are dropped entirely
// - address f is broadcast only, 0 adjacent, 1 line end, 2 network end
// - a second independent addressing machine serves the customer side
module ocf_framer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sync_word_loss,
  input wire logic cust_sync_word_loss,
  input wire logic rx_bit,
  input wire logic rx_bit_en,
  input wire logic tx_bit_en,
  input wire logic tx_frame_start,
  output logic tx_bit,
  input wire logic [7:0] fwd_data,
  input wire logic fwd_last,
  input wire logic fwd_valid,
  output logic fwd_ready,
  input wire logic cust_probe,
  input wire logic [7:0] cust_hop,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_first,
  output logic rx_last,
  output logic rx_process,
  output logic rx_forward,
  output logic rx_disc,
  output ocf_pkg::ocf_sm_e net_state,
  output ocf_pkg::ocf_sm_e cust_state,
  output logic [3:0] net_addr,
  output logic [3:0] cust_addr
);
  // 16-bit check update over one octet, lsb first
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `OCF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // addressing machines, index 0 network side, index 1 customer side
  // --------------------------------------------------------------------------
  ocf_pkg::ocf_sm_e sm_state_reg [2];
  logic [3:0] sm_addr_reg [2];
  logic [7:0] sm_hop_reg [2];
  logic sm_loss [2];
  logic sm_probe [2];
  logic [7:0] sm_hop_in [2];
  logic net_probe;
  logic [7:0] rx_mem [75];

  assign sm_loss[0] = sync_word_loss;
  assign sm_loss[1] = cust_sync_word_loss;
  assign sm_probe[0] = net_probe;
  assign sm_probe[1] = cust_probe;
  assign sm_hop_in[0] = rx_mem[2];
  assign sm_hop_in[1] = cust_hop;

  for (genvar s = 0; s < 2; s++)
  begin : g_sm
    wire [7:0] hop_inc = sm_hop_in[s] + 8'h01;
    // loss wins over a probe in the same cycle
    always_ff @(posedge clk)
    begin
      if (!nrst)
      begin
        sm_state_reg[s] <= ocf_pkg::OCF_OFFLINE;
        sm_addr_reg[s] <= `OCF_ADDR_ADJ;
        sm_hop_reg[s] <= 8'h00;
      end
      else
      begin
        case (sm_state_reg[s])
          ocf_pkg::OCF_OFFLINE:
          begin
            if (!sm_loss[s]) sm_state_reg[s] <= ocf_pkg::OCF_DISC_READY;
          end
          ocf_pkg::OCF_DISC_READY, ocf_pkg::OCF_ONLINE:
          begin
            if (sm_loss[s])
            begin
              sm_addr_reg[s] <= `OCF_ADDR_ADJ;
              sm_state_reg[s] <= ocf_pkg::OCF_OFFLINE;
            end
            else if (sm_probe[s])
            begin
              sm_hop_reg[s] <= hop_inc;
              sm_addr_reg[s] <= hop_inc[3:0] + `OCF_ADDR_OFS;
              sm_state_reg[s] <= ocf_pkg::OCF_ONLINE;
            end
          end
          default: sm_state_reg[s] <= ocf_pkg::OCF_OFFLINE;
        endcase
      end
    end
  end

  assign net_state = sm_state_reg[0];
  assign cust_state = sm_state_reg[1];
  assign net_addr = sm_addr_reg[0];
  assign cust_addr = sm_addr_reg[1];

  // --------------------------------------------------------------------------
  // receive: flag hunt, octet assembly, unstuffing, check
  // --------------------------------------------------------------------------
  logic [7:0] rx_sh_reg;
  logic [2:0] rx_bitcnt_reg;
  logic rx_locked_reg;
  logic [6:0] rx_len_reg;
  logic rx_esc_reg;
  logic rx_abort_reg;
  logic [15:0] rx_crc_reg;
  wire [7:0] rx_sh_next = {rx_bit, rx_sh_reg[7:1]}; // lsb arrives first
  wire rx_oct_v = rx_bit_en & rx_locked_reg & (rx_bitcnt_reg == 3'h7) & !sync_word_loss;
  wire rx_is_flag = (rx_sh_next == `OCF_FLAG);
  wire rx_pair_ok = (rx_sh_next == `OCF_ESC_FLAG) | (rx_sh_next == `OCF_ESC_ESC);
  wire rx_store = rx_oct_v & !rx_is_flag & !rx_abort_reg
    & (rx_esc_reg ? rx_pair_ok : (rx_sh_next != `OCF_ESC));
  wire [7:0] rx_store_b = rx_esc_reg ? (rx_sh_next ^ `OCF_ESC_XOR) : rx_sh_next;
  wire rx_end = rx_oct_v & rx_is_flag & ((rx_len_reg != 7'h00) | rx_esc_reg);
  wire rx_good = rx_end & !rx_abort_reg & !rx_esc_reg & (rx_len_reg >= `OCF_MIN_LEN)
    & (rx_len_reg <= `OCF_MAX_LEN) & (rx_crc_reg == `OCF_CRC_GOOD);
  wire rx_idle = (rx_len_reg == 7'h00) & !rx_esc_reg;

  // bit shifter and flag hunt
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rx_sh_reg <= 8'h00;
      rx_bitcnt_reg <= 3'h0;
      rx_locked_reg <= 1'b0;
    end
    else if (sync_word_loss)
    begin
      rx_locked_reg <= 1'b0;
    end
    else if (rx_bit_en)
    begin
      rx_sh_reg <= rx_sh_next;
      rx_bitcnt_reg <= rx_locked_reg ? rx_bitcnt_reg + 3'h1 : 3'h0;
      if (!rx_locked_reg && rx_is_flag) rx_locked_reg <= 1'b1;
    end
  end

  // frame accumulation, escape handling and running check
  always_ff @(posedge clk)
  begin
    if (!nrst || sync_word_loss || (rx_oct_v && rx_is_flag))
    begin
      rx_len_reg <= 7'h00;
      rx_esc_reg <= 1'b0;
      rx_abort_reg <= 1'b0;
      rx_crc_reg <= `OCF_CRC_INIT;
    end
    else if (rx_oct_v && !rx_abort_reg)
    begin
      rx_esc_reg <= !rx_esc_reg && (rx_sh_next == `OCF_ESC);
      if (rx_esc_reg && !rx_pair_ok) rx_abort_reg <= 1'b1;
      if (rx_store)
      begin
        if (rx_len_reg <= `OCF_MAX_LEN) rx_len_reg <= rx_len_reg + 7'h01;
        rx_crc_reg <= crc_upd(rx_crc_reg, rx_store_b);
      end
    end
  end

  // frame store, oversize content is not kept
  always_ff @(posedge clk)
  begin
    if (rx_store && rx_len_reg < `OCF_MAX_LEN) rx_mem[rx_len_reg] <= rx_store_b;
  end

  // --------------------------------------------------------------------------
  // network side routing of a good frame
  // --------------------------------------------------------------------------
  wire [3:0] r_dest = rx_mem[0][3:0];
  wire r_probe = (rx_mem[1] == `OCF_ID_PROBE);
  wire r_online = (net_state == ocf_pkg::OCF_ONLINE);
  wire r_ready = (net_state == ocf_pkg::OCF_DISC_READY);
  wire r_bcast = (r_dest == `OCF_ADDR_BCAST);
  wire r_mine = (r_dest == net_addr) | (r_dest == `OCF_ADDR_ADJ);
  wire r_disc = rx_good & r_probe & (r_online | r_ready);
  wire r_proc = rx_good & !r_probe & r_online & (r_bcast | r_mine);
  wire r_fwd = rx_good & !r_probe
    & ((r_online & (r_bcast | !r_mine)) | (r_ready & (r_dest != net_addr)));
  assign net_probe = r_disc & !sync_word_loss;

  // playout of the stored frame, check octets stripped
  logic pl_active_reg;
  logic [6:0] pl_idx_reg;
  logic [6:0] pl_cnt_reg;
  wire pl_last = (pl_idx_reg == pl_cnt_reg - 7'h01);
  wire [7:0] pl_byte = (rx_disc && pl_idx_reg == 7'h02) ? sm_hop_reg[0] : rx_mem[pl_idx_reg];

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pl_active_reg <= 1'b0;
      pl_idx_reg <= 7'h00;
      pl_cnt_reg <= 7'h00;
      {rx_valid, rx_first, rx_last, rx_process, rx_forward, rx_disc} <= 6'h00;
      rx_data <= 8'h00;
    end
    else if (!pl_active_reg)
    begin
      rx_valid <= 1'b0;
      if (net_probe | r_proc | r_fwd)
      begin
        pl_active_reg <= 1'b1;
        pl_idx_reg <= 7'h00;
        pl_cnt_reg <= rx_len_reg - 7'h02;
        rx_process <= r_proc;
        rx_forward <= r_fwd;
        rx_disc <= net_probe;
      end
    end
    else
    begin
      rx_valid <= 1'b1;
      rx_data <= pl_byte; // hop replaced by the incremented count on discovery
      rx_first <= (pl_idx_reg == 7'h00);
      rx_last <= pl_last;
      pl_idx_reg <= pl_idx_reg + 7'h01;
      if (pl_last) pl_active_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // transmit: forward fifo, response generator, octet scheduler, stuffing
  // --------------------------------------------------------------------------
  logic [8:0] fifo_out;
  logic fifo_vld;
  logic fifo_rd;
  ocf_pkg::ocf_tx_e tx_st_reg;
  logic tx_locked_reg;
  logic [2:0] tx_bitcnt_reg;
  logic [7:0] tx_sh_reg;
  logic [2:0] tx_flags_reg;
  logic tx_esc_reg;
  logic [7:0] tx_escb_reg;
  logic [15:0] tx_crc_reg;
  logic [6:0] tx_cnt_reg;
  logic tx_rsp_reg;
  logic [1:0] rsp_idx_reg;
  logic rsp_pend_reg;

  ocf_fifo #(.W(9), .D(`OCF_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_data({fwd_last, fwd_data}),
    .in_valid(fwd_valid),
    .in_ready(fwd_ready),
    .out_data(fifo_out),
    .out_valid(fifo_vld),
    .out_ready(fifo_rd)
  );

  // octet boundaries follow the line frame pair, first octet at bit one
  wire tx_load = tx_bit_en & (tx_bitcnt_reg == 3'h0) & (tx_locked_reg | tx_frame_start);
  wire [7:0] rsp_byte = (rsp_idx_reg == 2'h0) ? {net_addr, `OCF_ADDR_LTU}
    : (rsp_idx_reg == 2'h1) ? `OCF_ID_DRSP : sm_hop_reg[0];
  wire [7:0] src_byte = tx_rsp_reg ? rsp_byte : fifo_out[7:0];
  wire src_last = tx_rsp_reg ? (rsp_idx_reg == 2'h2) : fifo_out[8];
  wire src_have = tx_rsp_reg | fifo_vld;
  wire tx_may_fwd = fifo_vld & (r_online | (r_ready & rx_idle));
  wire tx_start_ok = rsp_pend_reg | tx_may_fwd;
  wire [7:0] tx_raw = (tx_st_reg == ocf_pkg::OCF_TX_FCS1) ? ~tx_crc_reg[7:0]
    : (tx_st_reg == ocf_pkg::OCF_TX_FCS2) ? ~tx_crc_reg[15:8] : src_byte;
  wire tx_in_frame = (tx_st_reg != ocf_pkg::OCF_TX_FLAG);
  wire tx_need_esc = tx_in_frame & ((tx_raw == `OCF_FLAG) | (tx_raw == `OCF_ESC));
  wire tx_abort = (tx_st_reg == ocf_pkg::OCF_TX_DATA) & !src_have;
  wire tx_take = tx_load & !tx_esc_reg & (tx_st_reg == ocf_pkg::OCF_TX_DATA) & src_have;
  wire tx_body_end = src_last | (tx_cnt_reg == `OCF_MAX_BODY - 7'h01);
  wire [7:0] tx_oct = tx_esc_reg ? (tx_escb_reg ^ `OCF_ESC_XOR)
    : !tx_in_frame ? `OCF_FLAG : (tx_abort | tx_need_esc) ? `OCF_ESC : tx_raw;
  wire tx_go = tx_load & !tx_esc_reg & !tx_in_frame
    & (tx_flags_reg >= `OCF_PRE_FLAGS - 3'h1) & tx_start_ok;

  // offline side drops queued forwards
  assign fifo_rd = (tx_take & !tx_rsp_reg) | (net_state == ocf_pkg::OCF_OFFLINE);

  // bit serializer, lsb first
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      tx_locked_reg <= 1'b0;
      tx_bitcnt_reg <= 3'h0;
      tx_sh_reg <= 8'hff;
      tx_bit <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_locked_reg <= 1'b1;
      tx_sh_reg <= tx_oct;
      tx_bit <= tx_oct[0];
      tx_bitcnt_reg <= 3'h1;
    end
    else if (tx_bit_en && tx_locked_reg)
    begin
      tx_bit <= tx_sh_reg[tx_bitcnt_reg];
      tx_bitcnt_reg <= tx_bitcnt_reg + 3'h1;
    end
  end

  // pending discovery response, a new probe wins over the clear
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rsp_pend_reg <= 1'b0;
    end
    else
    begin
      rsp_pend_reg <= net_probe | (rsp_pend_reg & !tx_go);
    end
  end

  // octet scheduler
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      tx_st_reg <= ocf_pkg::OCF_TX_FLAG;
      tx_flags_reg <= 3'h0;
      tx_esc_reg <= 1'b0;
      tx_escb_reg <= 8'h00;
      tx_crc_reg <= `OCF_CRC_INIT;
      tx_cnt_reg <= 7'h00;
      tx_rsp_reg <= 1'b0;
      rsp_idx_reg <= 2'h0;
    end
    else if (tx_load && tx_esc_reg)
    begin
      tx_esc_reg <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_esc_reg <= tx_need_esc & !tx_abort;
      tx_escb_reg <= tx_raw;
      case (tx_st_reg)
        ocf_pkg::OCF_TX_FLAG:
        begin
          if (tx_flags_reg != 3'h7) tx_flags_reg <= tx_flags_reg + 3'h1;
          if (tx_go)
          begin
            tx_st_reg <= ocf_pkg::OCF_TX_DATA;
            tx_crc_reg <= `OCF_CRC_INIT;
            tx_cnt_reg <= 7'h00;
            tx_rsp_reg <= rsp_pend_reg;
            rsp_idx_reg <= 2'h0;
          end
        end
        ocf_pkg::OCF_TX_DATA:
        begin
          if (!src_have)
          begin
            tx_st_reg <= ocf_pkg::OCF_TX_FLAG; // underrun: escape then flag aborts
            tx_flags_reg <= 3'h0;
          end
          else
          begin
            tx_crc_reg <= crc_upd(tx_crc_reg, tx_raw);
            tx_cnt_reg <= tx_cnt_reg + 7'h01;
            rsp_idx_reg <= rsp_idx_reg + 2'h1;
            if (tx_body_end) tx_st_reg <= ocf_pkg::OCF_TX_FCS1;
          end
        end
        ocf_pkg::OCF_TX_FCS1: tx_st_reg <= ocf_pkg::OCF_TX_FCS2;
        default:
        begin
          tx_st_reg <= ocf_pkg::OCF_TX_FLAG;
          tx_flags_reg <= 3'h0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_ready_on_clear: assert property (@(posedge clk) disable iff (!nrst)
    net_state == ocf_pkg::OCF_OFFLINE && !sync_word_loss |=> net_state == ocf_pkg::OCF_DISC_READY)
    else $error("offline side did not become discovery ready");
  a_loss_offline: assert property (@(posedge clk) disable iff (!nrst)
    net_state != ocf_pkg::OCF_OFFLINE && sync_word_loss
    |=> net_state == ocf_pkg::OCF_OFFLINE && net_addr == 4'h0)
    else $error("sync loss did not clear address");
  a_probe_addr: assert property (@(posedge clk) disable iff (!nrst)
    net_probe |=> net_state == ocf_pkg::OCF_ONLINE
    && net_addr == 4'($past(rx_mem[2]) + 8'h03) && rsp_pend_reg)
    else $error("probe did not set address and response");
  a_bcast_both: assert property (@(posedge clk) disable iff (!nrst)
    rx_good && r_online && r_bcast && !r_probe && !pl_active_reg
    |=> rx_process && rx_forward ##1 rx_valid && rx_first)
    else $error("broadcast not processed and forwarded");
  a_rx_lock: assert property (@(posedge clk) disable iff (!nrst)
    !sync_word_loss && rx_bit_en && !rx_locked_reg && rx_is_flag |=> rx_locked_reg)
    else $error("flag did not lock octet alignment");
  a_flag_run: assert property (@(posedge clk) disable iff (!nrst)
    tx_st_reg == ocf_pkg::OCF_TX_DATA && $past(tx_st_reg) == ocf_pkg::OCF_TX_FLAG
    |-> $past(tx_flags_reg) >= 3'h4)
    else $error("frame started after too few flags");
  a_stuff_pair: assert property (@(posedge clk) disable iff (!nrst)
    tx_load && !tx_esc_reg && tx_need_esc && !tx_abort
    |=> tx_sh_reg == `OCF_ESC && tx_esc_reg && tx_escb_reg == $past(tx_raw))
    else $error("payload octet not replaced by escape pair");
  a_bad_drop: assert property (@(posedge clk) disable iff (!nrst)
    rx_end && !rx_good && !pl_active_reg |=> !pl_active_reg ##1 !rx_valid)
    else $error("bad frame was passed on");
  a_abort_esc: assert property (@(posedge clk) disable iff (!nrst)
    rx_oct_v && rx_esc_reg && !rx_pair_ok && !rx_is_flag && !rx_abort_reg |=> rx_abort_reg)
    else $error("bad escape pair did not abort");
endmodule

// ==== ocf_peer.sv ====
// peer span unit: sends octets as channel bits, hunts flags in the framer's bits
// assumes one clk shared with the framer
module ocf_peer (
  input wire logic clk,
  output logic rx_bit = 1'b1,
  output logic rx_bit_en = 1'b0,
  input wire logic tx_bit,
  output logic tx_bit_en = 1'b0,
  output logic tx_frame_start = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [7:0] sh = 8'h7e;
  logic [7:0] rs = 8'hff;
  int dv = 0, bc = 0, fc = 0, rc = 0, runs = 0;
  bit lock = 0, esc = 0, short_lead = 0;
  // strobes every 10 clocks, 20 bits a line frame, idle line toggles
  always @(posedge clk)
  begin
    dv = (dv + 1) % 10;
    rx_bit_en <= (dv == 0);
    tx_bit_en <= (dv == 5);
    tx_frame_start <= (dv == 5) && (fc == 0);
    rx_bit <= (dv == 0) ? sh[0] : ~rx_bit;
    if (dv == 5)
      fc = (fc + 1) % 20;
    if (dv == 0)
      bc = (bc + 1) % 8;
    if (dv == 0)
      sh = (bc > 0) ? sh >> 1 : ((txq.size() > 0) ? txq.pop_front() : 8'h7e);
    if (dv == 4)
      rs = {tx_bit, rs[7:1]};
    if (dv == 4)
      rc = (rc + 1) % 8;
    // flag hunt, then octets with flags and escapes removed
    if (dv == 4 && !lock && rs == 8'h7e)
    begin
      lock = 1;
      rc = 0;
      runs = 1;
    end
    else if (dv == 4 && lock && rc == 0)
    begin
      if (rs != 8'h7e && runs > 0 && runs < 5)
        short_lead = 1;
      if (rs != 8'h7e && (rs != 8'h7d || esc))
        rxq.push_back(esc ? rs ^ 8'h20 : rs);
      esc = (rs == 8'h7d) && !esc;
      runs = (rs == 8'h7e) ? runs + 1 : 0;
    end
  end
endmodule

// ==== tb_ops_channel_hdlc_framer.sv ====
// testbench of the channel framer: discovery, routing, stuffing, check, forward fifo
// assumes the framer files and the peer model are compiled first
module tb_ops_channel_hdlc_framer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, sync_word_loss = 0, cust_sync_word_loss = 0;
  logic rx_bit, rx_bit_en, tx_bit_en, tx_frame_start, tx_bit;
  logic [7:0] fwd_data = 8'h00, cust_hop = 8'h00, rx_data;
  logic fwd_last = 0, fwd_valid = 0, fwd_ready, cust_probe = 0;
  logic rx_valid, rx_first, rx_last, rx_process, rx_forward, rx_disc;
  ocf_pkg::ocf_sm_e net_state, cust_state;
  logic [3:0] net_addr, cust_addr;
  logic [7:0] got[$];
  logic [2:0] pf;
  int n_mismatch = 0, comparisons = 0, last_at = 0;
  initial forever #4 clk = ~clk;
  ocf_framer u_dut (.clk, .nrst, .sync_word_loss, .cust_sync_word_loss, .rx_bit, .rx_bit_en,
    .tx_bit_en, .tx_frame_start, .tx_bit, .fwd_data, .fwd_last, .fwd_valid, .fwd_ready,
    .cust_probe, .cust_hop, .rx_valid, .rx_data, .rx_first, .rx_last, .rx_process,
    .rx_forward, .rx_disc, .net_state, .cust_state, .net_addr, .cust_addr);
  ocf_peer u_peer (.clk, .rx_bit, .rx_bit_en, .tx_bit, .tx_bit_en, .tx_frame_start);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] fcs(input logic [7:0] q[$]);
    logic [15:0] c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction
  // frame to the peer: lead flags, stuffed body, check low octet first; mode 1 bad check, 2 abort
  task automatic send(input logic [7:0] q[$], input int mode);
    logic [15:0] f;
    f = fcs(q) ^ ((mode == 1) ? 16'h0001 : 16'h0000);
    q.push_back(f[7:0]);
    q.push_back(f[15:8]);
    repeat (5) u_peer.txq.push_back(8'h7e);
    foreach (q[i])
    begin
      if (q[i] == 8'h7e || q[i] == 8'h7d)
        u_peer.txq.push_back(8'h7d);
      u_peer.txq.push_back((q[i] == 8'h7e || q[i] == 8'h7d) ? q[i] ^ 8'h20 : q[i]);
      if (mode == 2 && i == 0)
        u_peer.txq.push_back(8'h7d);
      if (mode == 2 && i == 0)
        u_peer.txq.push_back(8'h11);
    end
    u_peer.txq.push_back(8'h7e);
  endtask
  // collects one playout; a missing playout that was expected ends the run
  task automatic play(input bit exp);
    int t = 0;
    got.delete();
    last_at = -1;
    while (!(rx_valid === 1'b1 && rx_first === 1'b1) && t < 3000)
    begin
      tick(1);
      t++;
    end
    if (t >= 3000 && exp)
      n_mismatch++;
    if (t >= 3000 && exp)
      summarize();
    pf = {rx_process, rx_forward, rx_disc};
    while (rx_valid === 1'b1 && got.size() < 80)
    begin
      if (rx_last === 1'b1)
        last_at = got.size();
      got.push_back(rx_data);
      tick(1);
    end
  endtask
  task automatic hear(input int n);
    int t = 0;
    while (u_peer.rxq.size() < n && t < 8000)
    begin
      tick(1);
      t++;
    end
    if (t >= 8000)
      n_mismatch++;
    if (t >= 8000)
      summarize();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({net_state, net_addr, tx_bit, fwd_ready}, {ocf_pkg::OCF_OFFLINE, 4'h0, 2'b11});
    @(posedge clk);
    nrst <= 1'b1;
    tick(2);
    chk({net_state, cust_state}, {ocf_pkg::OCF_DISC_READY, ocf_pkg::OCF_DISC_READY});
  endtask
  task automatic t_probe();
    logic [7:0] r[$];
    logic [15:0] f;
    for (int h = 0; h < 8; h += 4)
    begin
      u_peer.rxq.delete();
      send('{8'h10, 8'h01, h[7:0], 8'h7d}, 0);
      play(1);
      chk({got[0], got[1], got[2], got[3]}, {16'h1001, h[7:0] + 8'h01, 8'h7d});
      chk({pf[1:0], net_state, net_addr}, {2'b01, ocf_pkg::OCF_ONLINE, h[3:0] + 4'h3});
      r = '{{h[3:0] + 4'h3, 4'h1}, 8'h81, h[7:0] + 8'h01};
      f = fcs(r);
      hear(5);
      chk({u_peer.rxq[0], u_peer.rxq[1], u_peer.rxq[2], u_peer.rxq[3], u_peer.rxq[4]},
        {r[0], r[1], r[2], f[7:0], f[15:8]});
      chk(u_peer.short_lead, 1'b0);
    end
  endtask
  task automatic t_route();
    logic [3:0] d[4] = '{4'hf, 4'h0, 4'h7, 4'h5};
    logic [1:0] e[4] = '{2'b11, 2'b10, 2'b10, 2'b01};
    for (int i = 0; i < 4; i++)
    begin
      send('{{4'h1, d[i]}, 8'h0b, 8'h7e}, 0);
      play(1);
      chk({got[0], got[2], pf[2:1]}, {4'h1, d[i], 8'h7e, e[i]});
      chk({got.size(), last_at}, {32'd3, 32'd2});
    end
  endtask
  task automatic t_bad();
    logic [7:0] q[$];
    for (int m = 1; m < 4; m++)
    begin
      q = '{8'h01, 8'h0b, 8'h22};
      if (m == 3)
        q = '{8'h01};
      send(q, m % 3);
      play(0);
      chk(got.size(), 0);
    end
  endtask
  task automatic t_fwd();
    logic [7:0] q[$] = '{8'h51, 8'h0b, 8'h7e, 8'h7d, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
    logic [15:0] f;
    bit full = 0;
    int t;
    u_peer.rxq.delete();
    @(posedge clk);
    fwd_valid <= 1'b1;
    foreach (q[i])
    begin
      fwd_data <= q[i];
      fwd_last <= (i == 9);
      // ready is read settled, one step after the edge, for the next edge
      #1;
      t = 0;
      while (fwd_ready !== 1'b1 && t < 2000)
      begin
        full = 1;
        tick(1);
        t++;
      end
      if (t >= 2000)
        n_mismatch++;
      if (t >= 2000)
        summarize();
      @(posedge clk);
    end
    fwd_valid <= 1'b0;
    chk(full, 1'b1);
    f = fcs(q);
    hear(12);
    foreach (q[i])
      chk(u_peer.rxq[i], q[i]);
    chk({u_peer.rxq[10], u_peer.rxq[11]}, {f[7:0], f[15:8]});
  endtask
  task automatic t_side();
    @(posedge clk);
    cust_hop <= 8'h04;
    cust_probe <= 1'b1;
    sync_word_loss <= 1'b1;
    @(posedge clk);
    cust_probe <= 1'b0;
    tick(2);
    chk({cust_state, cust_addr}, {ocf_pkg::OCF_ONLINE, 4'h7});
    chk({net_state, net_addr}, {ocf_pkg::OCF_OFFLINE, 4'h0});
    @(posedge clk);
    sync_word_loss <= 1'b0;
    cust_sync_word_loss <= 1'b1;
    tick(2);
    chk(net_state, ocf_pkg::OCF_DISC_READY);
    chk({cust_state, cust_addr}, {ocf_pkg::OCF_OFFLINE, 4'h0});
    send('{8'h15, 8'h0b}, 0);
    play(1);
    chk({got[0], pf[2:1]}, {8'h15, 2'b01});
  endtask
  initial
  begin
    tick(3);
    t_reset();
    t_probe();
    t_route();
    t_bad();
    t_fwd();
    t_side();
    summarize();
  end
endmodule
